// ### verilog/scg_defs.svh
// Constants for the system clock generation block.
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH
`define SCG_CFG_W          8'h20
`define SCG_BUSCLK_N       3
`define SCG_SYSMUL_LSB     0
`define SCG_SYSMUL_W       4
`define SCG_CORESET_LSB    4
`define SCG_CORESET_W      3
`define SCG_MEMRATIO_BIT   7
`define SCG_LOCRATIO_BIT   8
`define SCG_HARD_CFG0      32'h0000_0114
`define SCG_HARD_CFG1      32'h0000_0124
`define SCG_LOCDIV_W       5
`define SCG_LOCDIV_RST     5'h02
`define SCG_UNIT_N         2
`define SCG_UNIT_RATIO_RST 4'h1
`define SCG_OUTEN_RST      3'h7
`define SCG_ADDR_OUTEN     4'h0
`define SCG_ADDR_LOCDIV    4'h4
`define SCG_ADDR_UNIT      4'h8
`define SCG_ADDR_STAT      4'hC
`endif

// ### verilog/scg_pkg.sv
// Types shared by the system clock generation modules.
package scg_pkg;
  typedef logic [3:0] scg_ratio_t;
  typedef enum logic [1:0] {
    SCG_SRC_PIN   = 2'b00,
    SCG_SRC_HARD0 = 2'b01,
    SCG_SRC_HARD1 = 2'b10
  } scg_src_e;
endpackage

// ### verilog/scg_div_if.sv
// Carrier between the top and a clock-enable divider.
`timescale 1ns/1ps
interface scg_div_if;
  logic       in_en;
  logic [7:0] ratio;
  logic       out_en;
  logic       tog;
  modport owner (output in_en, output ratio, input out_en, input tog);
  modport div   (input in_en, input ratio, output out_en, output tog);
endinterface

// ### verilog/scg_div.sv
// Divide-by-N enable divider: pulse every N input enables, plus a toggle.
`timescale 1ns/1ps
module scg_div (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  scg_div_if.div    d
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       en;
    logic       tog;
  } scg_div_s;
  scg_div_s st_reg;
  scg_div_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.en = 1'b0;
    if (d.in_en) begin
      if (st_reg.cnt + 8'h01 >= d.ratio) begin
        st_next.cnt = 8'h00;
        st_next.en  = 1'b1;
        st_next.tog = ~st_reg.tog;
      end else begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign d.out_en = st_reg.en;
  assign d.tog    = st_reg.tog;
endmodule

// ### verilog/scg_top.sv
// System clock generation: mode select, sync/bus clocks and enable dividers.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "scg_defs.svh"

// How it works
// - Host strap selects system clock as reference.
// - Host: system clock feeds halver and muxes.
// - Halving select picks full or halved sync.
// - Per-output enable gates sync onto bus clocks.
// - Agent strap selects bus clock input reference.
// - Bus clock is sync times factor times multiplier.
// - Core clock is bus clock times core setting.
// - Multipliers come from latched or hard word.
// - Memory clock ratio, halved for bus output.
// - Local clock ratio, divided for two outputs.
// - Units default ratio, software may change/stop.
module scg_top #(
  parameter int BUSCLK_N = `SCG_BUSCLK_N,
  parameter int UNIT_N   = `SCG_UNIT_N
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     host_mode_i,
  input  wire logic                     primary_sys_clock_input_i,
  input  wire logic                     bus_clock_input_i,
  input  wire logic                     sync_clock_input_i,
  input  wire logic                     input_halving_select_i,
  input  wire logic [1:0]               cfg_source_i,
  input  wire logic [31:0]              reset_config_word_low_i,
  input  wire logic [3:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [31:0]              rdata_o,
  output logic                          sync_clock_output_o,
  output logic      [BUSCLK_N-1:0]      bus_clock_outputs_o,
  output logic                          sys_bus_clk_en_o,
  output logic                          core_clk_en_o,
  output logic                          mem_clk_en_o,
  output logic                          memory_bus_clock_out_o,
  output logic                          memory_bus_clock_out_n_o,
  output logic                          lbc_clk_en_o,
  output logic      [1:0]               local_bus_clock_out_o,
  output logic      [UNIT_N-1:0]        unit_clk_en_o
);
  typedef struct packed {
    logic [2:0]             psc;
    logic [2:0]             bsc;
    logic [2:0]             ysc;
    logic                   ref_lvl;
    logic                   half_tog;
    logic                   sync_lvl;
    logic [BUSCLK_N-1:0]    bus_out;
    logic                   ref_edge;
    logic                   sync_edge;
    logic                   latched;
    logic                   host;
    logic                   half_sel;
    logic [31:0]            rcw;
    logic [BUSCLK_N-1:0]    out_en_mask;
    logic [`SCG_LOCDIV_W-1:0] loc_div;
    logic [UNIT_N*4-1:0]    unit_ratio;
    logic [31:0]            rdata;
    logic                   mem_pend;
    logic                   lbc_pend;
  } scg_top_s;
  scg_top_s st_reg;
  scg_top_s st_next;

  scg_div_if sysmul_if ();
  scg_div_if core_if ();
  scg_div_if mem_if ();
  scg_div_if lbcint_if ();
  scg_div_if lbc_if ();
  scg_div_if unit_if [UNIT_N] ();

  logic ref_sel;
  logic [31:0] hard_word;
  logic [31:0] rcw_src;

  // The three-stage pin capture; only stages two and three are compared.
  always_comb begin
    ref_sel = st_reg.host ? st_reg.psc[2] : st_reg.bsc[2];
    hard_word = (cfg_source_i == 2'(scg_pkg::SCG_SRC_HARD1)) ? `SCG_HARD_CFG1 : `SCG_HARD_CFG0;
    rcw_src = (cfg_source_i == 2'(scg_pkg::SCG_SRC_PIN)) ? reset_config_word_low_i : hard_word;
  end

  always_comb begin
    st_next = st_reg;
    st_next.psc = {st_reg.psc[1:0], primary_sys_clock_input_i};
    st_next.bsc = {st_reg.bsc[1:0], bus_clock_input_i};
    st_next.ysc = {st_reg.ysc[1:0], sync_clock_input_i};
    st_next.rdata = 32'h0000_0000;
    // Straps are caught on the first clocked cycle after reset and then frozen.
    if (!st_reg.latched) begin
      st_next.latched  = 1'b1;
      st_next.host     = host_mode_i;
      st_next.half_sel = input_halving_select_i;
      st_next.rcw      = rcw_src;
    end
    // A rising reference edge counts once the two settled stages agree on a new level.
    st_next.ref_edge = 1'b0;
    if (st_reg.host ? (st_reg.psc[2] == st_reg.psc[1]) : (st_reg.bsc[2] == st_reg.bsc[1])) begin
      if ((st_reg.host ? st_reg.psc[1] : st_reg.bsc[1]) != st_reg.ref_lvl) begin
        st_next.ref_lvl = ~st_reg.ref_lvl;
        if (!st_reg.ref_lvl) begin
          st_next.ref_edge = 1'b1;
          st_next.half_tog = ~st_reg.half_tog;
        end
      end
    end
    if (st_reg.host) begin
      // Halved sync toggles once per reference rising edge.
      st_next.sync_lvl = st_reg.half_sel ? st_reg.half_tog : ref_sel;
    end else begin
      st_next.sync_lvl = 1'b0;
    end
    for (int i = 0; i < BUSCLK_N; i++) begin
      st_next.bus_out[i] = st_reg.host & st_reg.out_en_mask[i] & st_reg.sync_lvl;
    end
    // The looped-back sync input only feeds sync_edge, which nothing reads; the system multiplier runs on the latched tick.
    st_next.sync_edge = (st_reg.ysc[2] == st_reg.ysc[1]) && st_reg.ysc[1] && !st_reg.ysc[2];
    st_next.sync_edge = st_reg.ysc[1] & st_reg.ysc[2] & ~st_reg.sync_lvl & st_reg.host ? 1'b0 : st_next.sync_edge;
    st_next.mem_pend = 1'b0;
    st_next.lbc_pend = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        `SCG_ADDR_OUTEN:  st_next.out_en_mask = wdata_i[BUSCLK_N-1:0];
        `SCG_ADDR_LOCDIV: st_next.loc_div     = wdata_i[`SCG_LOCDIV_W-1:0];
        `SCG_ADDR_UNIT: st_next.unit_ratio = wdata_i[UNIT_N*4-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `SCG_ADDR_OUTEN:  st_next.rdata = 32'(st_reg.out_en_mask);
        `SCG_ADDR_LOCDIV: st_next.rdata = 32'(st_reg.loc_div);
        `SCG_ADDR_UNIT: st_next.rdata = 32'(st_reg.unit_ratio);
        `SCG_ADDR_STAT: st_next.rdata = {st_reg.rcw[23:0], 5'h00, st_reg.half_sel, st_reg.host, st_reg.latched};
        default:        st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg            <= '0;
      st_reg.out_en_mask <= BUSCLK_N'(`SCG_OUTEN_RST);
      st_reg.loc_div     <= `SCG_LOCDIV_RST;
      st_reg.unit_ratio <= {UNIT_N{`SCG_UNIT_RATIO_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // The latched tick, not the input reference, drives the multiplier chain; a true PLL multiplies,
  // here the ratios divide a fast free-running tick so relative rates hold.
  logic [`SCG_SYSMUL_W-1:0]  sys_mul;
  logic [`SCG_CORESET_W-1:0] core_set;
  logic [7:0]                bus_ratio;
  logic [7:0]                core_ratio;
  logic                      mem_tog_reg;
  assign sys_mul  = st_reg.rcw[`SCG_SYSMUL_LSB +: `SCG_SYSMUL_W];
  assign core_set = st_reg.rcw[`SCG_CORESET_LSB +: `SCG_CORESET_W];
  // The bus period is kept even so that the doubled memory and local rates divide it exactly.
  assign bus_ratio = 8'(sys_mul) * (st_reg.half_sel ? 8'h02 : 8'h04);

  // A faster core clock means a shorter period; a zero setting falls back to the bus rate.
  always_comb begin
    if (core_set == '0) begin
      core_ratio = bus_ratio;
    end else begin
      core_ratio = bus_ratio / 8'(core_set);
    end
    if (core_ratio == 8'h00) begin
      core_ratio = 8'h01;
    end
  end

  // Bus clock: input factor times system multiplier.
  assign sysmul_if.in_en = st_reg.latched;
  assign sysmul_if.ratio = bus_ratio;
  scg_div u_sysmul (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(sysmul_if));

  // Core clock: bus clock rate times the core setting.
  assign core_if.in_en = st_reg.latched;
  assign core_if.ratio = core_ratio;
  scg_div u_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(core_if));

  // Internal memory rate: the bus period halved when the ratio bit is set.
  assign mem_if.in_en = st_reg.latched;
  assign mem_if.ratio = bus_ratio >> st_reg.rcw[`SCG_MEMRATIO_BIT];
  scg_div u_mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(mem_if));

  // Internal local rate, doubled by its ratio bit, then cut by the divider field for the pins.
  assign lbcint_if.in_en = st_reg.latched;
  assign lbcint_if.ratio = bus_ratio >> st_reg.rcw[`SCG_LOCRATIO_BIT];
  scg_div u_lbcint (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(lbcint_if));
  assign lbc_if.in_en = lbcint_if.out_en;
  assign lbc_if.ratio = 8'(st_reg.loc_div);
  scg_div u_lbc (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(lbc_if));

  generate
    for (genvar g = 0; g < UNIT_N; g++) begin : g_unit
      assign unit_if[g].in_en = sysmul_if.out_en;
      assign unit_if[g].ratio = 8'(st_reg.unit_ratio[g*4 +: 4]);
      scg_div u_unit (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(unit_if[g]));
      // A zero ratio stops the unit clock entirely.
      assign unit_clk_en_o[g] = unit_if[g].out_en & (st_reg.unit_ratio[g*4 +: 4] != 4'h0);
    end
  endgenerate

  // Memory clock: bus rate, doubled by the ratio bit; external pair halves it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_tog_reg <= 1'b0;
    end else if (mem_clk_en_o) begin
      mem_tog_reg <= ~mem_tog_reg;
    end
  end
  assign mem_clk_en_o = mem_if.out_en;

  assign rdata_o                  = st_reg.rdata;
  assign sync_clock_output_o      = st_reg.sync_lvl;
  assign bus_clock_outputs_o      = st_reg.bus_out;
  assign sys_bus_clk_en_o         = sysmul_if.out_en;
  assign core_clk_en_o            = core_if.out_en;
  assign memory_bus_clock_out_o   = mem_tog_reg;
  assign memory_bus_clock_out_n_o = ~mem_tog_reg;
  assign lbc_clk_en_o             = lbcint_if.out_en;
  assign local_bus_clock_out_o    = {2{lbc_if.tog}};
endmodule

// ### testbench/scg_chk.sv
// Port-level assertions for the system clock generation top.
`timescale 1ns/1ps
module scg_chk #(
  parameter int BUSCLK_N = 3,
  parameter int UNIT_N   = 2
) (
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire logic                host_mode_i,
  input wire logic [3:0]          addr_i,
  input wire logic [31:0]         wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  input wire logic                sync_clock_output_o,
  input wire logic [BUSCLK_N-1:0] bus_clock_outputs_o,
  input wire logic                mem_clk_en_o,
  input wire logic                memory_bus_clock_out_o,
  input wire logic                memory_bus_clock_out_n_o,
  input wire logic [1:0]          local_bus_clock_out_o,
  input wire logic [UNIT_N-1:0]   unit_clk_en_o
);
  logic [3:0] up_reg;
  logic [3:0] u0_reg;
  logic [3:0] zr_reg;
  // Saturating counters give a post-reset guard and a margin for a stopped unit to drain.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_reg <= 4'h0;
      u0_reg <= 4'h1;
      zr_reg <= 4'h0;
    end else begin
      up_reg <= (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
      u0_reg <= (wr_i && addr_i == 4'h8) ? wdata_i[3:0] : u0_reg;
      zr_reg <= (u0_reg != 4'h0) ? 4'h0 : (zr_reg == 4'hf) ? zr_reg : zr_reg + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read answer");
  unmapped_rd_a: assert property ($past(rd_i) && ($past(addr_i) & 4'h3) != 4'h0 |-> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  memclk_pair_a: assert property (memory_bus_clock_out_n_o == ~memory_bus_clock_out_o)
    else $error("memory clock pair not complementary");
  memclk_step_a: assert property (up_reg > 4'h1 && $changed(memory_bus_clock_out_o) |-> mem_clk_en_o || $past(mem_clk_en_o))
    else $error("memory clock moved without enable");
  locclk_pair_a: assert property (local_bus_clock_out_o[0] == local_bus_clock_out_o[1])
    else $error("local clock outputs differ");
  busclk_gate_a: assert property (|bus_clock_outputs_o |-> $past(sync_clock_output_o))
    else $error("bus clock high without sync");
  agent_sync_a: assert property (up_reg > 4'h2 && !host_mode_i |-> !sync_clock_output_o)
    else $error("sync output driven in agent mode");
  unit_stop_a: assert property (zr_reg > 4'h5 |-> !unit_clk_en_o[0])
    else $error("stopped unit still enabled");
  cover property (rd_i);
  cover property (|bus_clock_outputs_o);
  cover property ($rose(local_bus_clock_out_o[0]));
endmodule
bind scg_top scg_chk #(.BUSCLK_N(BUSCLK_N), .UNIT_N(UNIT_N)) u_scg_chk (.ref_clk_i, .rst_i, .host_mode_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sync_clock_output_o, .bus_clock_outputs_o, .mem_clk_en_o,
  .memory_bus_clock_out_o, .memory_bus_clock_out_n_o, .local_bus_clock_out_o, .unit_clk_en_o);

// ### testbench/scg_clk_src.sv
// Board model: system and bus clock sources plus the sync loopback wire.
`timescale 1ns/1ps
module scg_clk_src #(
  parameter int HALF_SYS = 110,
  parameter int HALF_BUS = 130,
  parameter int LOOP_DLY = 3
) (
  input  wire logic host_mode_i,
  input  wire logic sync_out_i,
  output logic      sys_clk_o,
  output logic      bus_clk_o,
  output logic      sync_in_o
);
  logic osc = 1'b0;
  initial forever #(HALF_SYS) osc = ~osc;
  initial begin
    bus_clk_o = 1'b0;
    sync_in_o = 1'b0;
    forever #(HALF_BUS) bus_clk_o = ~bus_clk_o;
  end
  assign sys_clk_o = host_mode_i & osc; // grounded when agent
  always @(sync_out_i) sync_in_o <= #(LOOP_DLY) sync_out_i;
endmodule

// ### testbench/system_clock_generation_tb_top.sv
// Self-checking bench for the system clock generation top.
`timescale 1ns/1ps
`include "scg_defs.svh"
module system_clock_generation_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        host = 1'b1;
  logic        halve = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  src = 2'b00;
  logic [3:0]  addr = 4'h0;
  logic [31:0] rcw = 32'h0000_0011;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] seed = 32'h09a6_67c2;
  logic [31:0] rdata;
  logic [2:0]  bclk;
  logic [1:0]  loc_out, uen;
  logic        sync_o, sys_en, core_en, mem_en, mem_pair, lbc_en, psys, pbus, psync;
  int          miscompares = 0;
  int          checks = 0;
  int          cnt[13];
  initial forever #12.5 clk = ~clk;
  scg_top u_scg_top (.ref_clk_i(clk), .rst_i(rst), .host_mode_i(host), .primary_sys_clock_input_i(psys),
    .bus_clock_input_i(pbus), .sync_clock_input_i(psync), .input_halving_select_i(halve), .cfg_source_i(src),
    .reset_config_word_low_i(rcw), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .sync_clock_output_o(sync_o), .bus_clock_outputs_o(bclk), .sys_bus_clk_en_o(sys_en), .core_clk_en_o(core_en),
    .mem_clk_en_o(mem_en), .memory_bus_clock_out_o(mem_pair), .memory_bus_clock_out_n_o(), .lbc_clk_en_o(lbc_en),
    .local_bus_clock_out_o(loc_out), .unit_clk_en_o(uen));
  scg_clk_src u_scg_clk_src (.host_mode_i(host), .sync_out_i(sync_o), .sys_clk_o(psys), .bus_clk_o(pbus),
    .sync_in_o(psync));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Rates come from counted enables, so a small slack absorbs phase at the window edges.
  function automatic logic near(input int a, input int b);
    return (a - b <= b / 8 + 2) && (b - a <= b / 8 + 2);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic measure(input int n);
    logic [3:0] prv;
    logic [3:0] cur;
    logic [8:0] pv;
    cnt = '{default: 0};
    prv = {mem_pair, loc_out[0], sync_o, psys};
    repeat (n) begin
      @(posedge clk);
      #1;
      cur = {mem_pair, loc_out[0], sync_o, psys};
      pv = {uen, bclk, lbc_en, mem_en, core_en, sys_en};
      for (int k = 0; k < 9; k++) cnt[k] += pv[k];
      for (int k = 0; k < 4; k++) cnt[9 + k] += (cur[k] != prv[k]);
      prv = cur;
    end
  endtask
  task automatic run(input logic h, input logic hv, input logic [1:0] s);
    logic [31:0] w;
    logic [3:0]  u1;
    logic [2:0]  oc;
    int          dv;
    rst <= 1'b1;
    host <= h;
    halve <= hv;
    src <= s;
    rcw <= seed | 32'h0000_0011;
    w = (s == 2'b01) ? `SCG_HARD_CFG0 : (s == 2'b10) ? `SCG_HARD_CFG1 : (seed | 32'h0000_0011);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(4'h0, 32'h0000_0007);
    rd_chk(4'h4, 32'h0000_0002);
    rd_chk(4'h8, 32'h0000_0011);
    rd_chk(4'hC, {w[23:0], 5'h00, hv, h, 1'b1});
    oc = seed[14:12];
    u1 = seed[11:8];
    dv = 2 + seed[4:3];
    wr_reg(4'h0, {29'h0, oc});
    wr_reg(4'h4, 32'(dv));
    wr_reg(4'h8, {24'h0, u1, 4'h0});
    wr_reg(4'h2, 32'hffff_ffff);
    rd_chk(4'h1, 32'h0000_0000);
    rd_chk(4'h0, {29'h0, oc});
    // Long enough that the slowest bus rate gives twenty pulses, so divider phase stays inside the slack.
    measure(1200);
    chk(cnt[0] > 0, 1);
    chk(cnt[1] >= cnt[0], 1);
    chk(near(cnt[2], cnt[0] * (1 + w[7])), 1);
    chk(near(cnt[12], cnt[2]), 1);
    chk(near(cnt[3], cnt[0] * (1 + w[8])), 1);
    chk(near(cnt[11] * dv, cnt[3]), 1);
    chk(cnt[10] > 0, h);
    if (h) chk(near(cnt[10] * (1 + hv), cnt[9]), 1);
    for (int k = 0; k < 3; k++) chk(cnt[4 + k] > 0, oc[k] & h);
    chk(cnt[7], 0);
    chk(cnt[8] > 0, |u1);
    $display("test done host %0b halve %0b source %0d", h, hv, s);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    for (int t = 0; t < 4; t++) begin
      seed = lfsr(seed);
      run(t != 2, t[0], (t == 3) ? 2'b00 : 2'(t));
    end
    finish_test();
  end
  // Four runs of about 1240 cycles each fit well inside this span.
  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
